// file: logic/dsl_pkg.sv
// Package: constants, register map and decode functions of the slew limiter
package dsl_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Clocking
	localparam int unsigned CLK_HZ     = 50_000_000;
	localparam int unsigned OSC_HZ_DEF = 13_000_000;
	localparam int unsigned CHANNELS   = 4;

	////////////////////////////////////////////////////////////////////////////////
	// Register map, byte addresses
	localparam logic [7:0] MAP_LIMIT    = 8'h40;
	localparam logic [1:0] REG_TARGET   = 2'h0;
	localparam logic [1:0] REG_CLEARVAL = 2'h1;
	localparam logic [1:0] REG_CONTROL  = 2'h2;
	localparam logic [1:0] REG_STATUS   = 2'h3;
	localparam int unsigned ADDR_CH_LSB  = 4;
	localparam int unsigned ADDR_REG_LSB = 2;

	// Control register fields
	localparam int unsigned CTRL_SLEW_BIT   = 0;
	localparam int unsigned CTRL_RATE_LSB   = 1;
	localparam int unsigned CTRL_STEP_LSB   = 5;
	localparam int unsigned CTRL_CLRALW_BIT = 8;
	localparam int unsigned CTRL_OUTEN_BIT  = 9;
	localparam int unsigned CTRL_WIDTH      = 10;
	localparam int unsigned STAT_BUSY_BIT   = 16;

	// Reset values
	localparam logic [15:0] RST_CODE = 16'h0000;
	localparam logic [9:0]  RST_CTRL = 10'h000;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	////////////////////////////////////////////////////////////////////////////////
	// Channel states
	typedef enum logic [1:0] {
		CH_IDLE = 2'b01,
		CH_RAMP = 2'b10
	} dsl_chst_e;

	////////////////////////////////////////////////////////////////////////////////
	// Update rate in millihertz per selector code
	function automatic logic [63:0] dsl_rate_mhz(input logic [3:0] sel);
		case (sel)
			4'h0:    dsl_rate_mhz = 64'd64_000_000;
			4'h1:    dsl_rate_mhz = 64'd32_000_000;
			4'h2:    dsl_rate_mhz = 64'd16_000_000;
			4'h3:    dsl_rate_mhz = 64'd8_000_000;
			4'h4:    dsl_rate_mhz = 64'd4_000_000;
			4'h5:    dsl_rate_mhz = 64'd2_000_000;
			4'h6:    dsl_rate_mhz = 64'd1_000_000;
			4'h7:    dsl_rate_mhz = 64'd500_000;
			4'h8:    dsl_rate_mhz = 64'd250_000;
			4'h9:    dsl_rate_mhz = 64'd125_000;
			4'hA:    dsl_rate_mhz = 64'd64_000;
			4'hB:    dsl_rate_mhz = 64'd32_000;
			4'hC:    dsl_rate_mhz = 64'd16_000;
			4'hD:    dsl_rate_mhz = 64'd8_000;
			4'hE:    dsl_rate_mhz = 64'd4_000;
			default: dsl_rate_mhz = 64'd500;
		endcase
	endfunction

	// Oscillator ticks per update, never below one
	function automatic logic [31:0] dsl_divisor(input logic [31:0] oscHz,
		input logic [3:0] sel);
		logic [63:0] q;
		q = ({32'h0000_0000, oscHz} * 64'd1000) / dsl_rate_mhz(sel);
		dsl_divisor = (q == 64'h0000_0000_0000_0000) ? 32'h0000_0001 : q[31:0];
	endfunction

	// Step size in code LSBs per selector code
	function automatic logic [15:0] dsl_step_lsb(input logic [2:0] sel);
		case (sel)
			3'h0:    dsl_step_lsb = 16'h0001;
			3'h1:    dsl_step_lsb = 16'h0002;
			3'h2:    dsl_step_lsb = 16'h0004;
			3'h3:    dsl_step_lsb = 16'h0010;
			3'h4:    dsl_step_lsb = 16'h0020;
			3'h5:    dsl_step_lsb = 16'h0040;
			3'h6:    dsl_step_lsb = 16'h0080;
			default: dsl_step_lsb = 16'h0100;
		endcase
	endfunction

	// Distance between two codes
	function automatic logic [15:0] dsl_dist(input logic [15:0] a, input logic [15:0] b);
		dsl_dist = (a > b) ? (a - b) : (b - a);
	endfunction

endpackage

// file: logic/dsl_channel.sv
// One converter channel: target, clear target and digital stepping
`timescale 1ns/1ps
module dsl_channel
	import dsl_pkg::*;
#(
	parameter logic [31:0] OSC_HZ = 32'd13_000_000
) (
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        oscTick,
	input  wire logic        slewEnable,
	input  wire logic [3:0]  rateSel,
	input  wire logic [2:0]  stepSel,
	input  wire logic [15:0] target,
	input  wire logic        loadStrobe,
	input  wire logic [15:0] clearCode,
	input  wire logic        clearStrobe,
	input  wire logic        clearDirect,
	output logic      [15:0] code,
	output logic             busy
);

	typedef struct packed {
		dsl_chst_e   state;
		logic [15:0] code;
		logic [15:0] goal;
		logic [31:0] divCnt;
	} dsl_ch_s;

	dsl_ch_s     st;
	dsl_ch_s     next_st;
	logic [31:0] divisor;
	logic [15:0] stepVal;
	logic        stepFire;

	assign divisor = dsl_divisor(OSC_HZ, rateSel);
	assign stepVal = dsl_step_lsb(stepSel);
	assign code    = st.code;
	assign busy    = (st.state == CH_RAMP);

	////////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		next_st  = st;
		stepFire = 1'b0;
		if (loadStrobe) begin
			next_st.goal = target;
		end
		if (clearStrobe) begin
			next_st.goal = clearCode;
		end
		if (!slewEnable) begin
			next_st.code   = next_st.goal;
			next_st.divCnt = 32'h0000_0000;
		end else if (clearStrobe && clearDirect) begin
			next_st.code   = clearCode;
			next_st.divCnt = 32'h0000_0000;
		end else if (next_st.goal == st.code) begin
			next_st.divCnt = 32'h0000_0000;
		end else if (oscTick) begin
			if (st.divCnt >= divisor - 32'h0000_0001) begin
				next_st.divCnt = 32'h0000_0000;
				stepFire       = 1'b1;
				if (dsl_dist(next_st.goal, st.code) <= stepVal) begin
					next_st.code = next_st.goal;
				end else if (next_st.goal > st.code) begin
					next_st.code = st.code + stepVal;
				end else begin
					next_st.code = st.code - stepVal;
				end
			end else begin
				next_st.divCnt = st.divCnt + 32'h0000_0001;
			end
		end
		case (next_st.goal != next_st.code)
			1'b1:    next_st.state = CH_RAMP;
			default: next_st.state = CH_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '{state: CH_IDLE, code: RST_CODE, goal: RST_CODE, divCnt: 32'h0000_0000};
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_off_load;
		!slewEnable && loadStrobe && !clearStrobe;
	endsequence

	sequence s_landed;
		(code == st.goal) && !busy;
	endsequence

	property p_off_direct;
		@(posedge ref_clk) disable iff (!rst_n)
		s_off_load |=> (code == $past(target));
	endproperty
	a_off_direct: assert property (p_off_direct) else $error("direct load missed");

	property p_step_bound;
		@(posedge ref_clk) disable iff (!rst_n)
		($past(slewEnable) && !$past(clearStrobe && clearDirect))
		|-> (dsl_dist(code, $past(code)) <= dsl_step_lsb($past(stepSel)));
	endproperty
	a_step_bound: assert property (p_step_bound) else $error("step too large");

	property p_full_step;
		@(posedge ref_clk) disable iff (!rst_n)
		(stepFire && !loadStrobe && !clearStrobe && (dsl_dist(st.goal, st.code) > stepVal))
		|=> (dsl_dist(code, $past(code)) == $past(stepVal)) && busy;
	endproperty
	a_full_step: assert property (p_full_step) else $error("step size wrong");

	property p_land;
		@(posedge ref_clk) disable iff (!rst_n)
		(stepFire && !loadStrobe && !clearStrobe && (dsl_dist(st.goal, st.code) <= stepVal))
		|=> s_landed;
	endproperty
	a_land: assert property (p_land) else $error("overshoot or no stop");

	property p_div_range;
		@(posedge ref_clk) disable iff (!rst_n)
		($stable(rateSel) && $past(slewEnable)) |-> (st.divCnt < divisor);
	endproperty
	a_div_range: assert property (p_div_range) else $error("divider overrun");

endmodule

// file: logic/dsl_top.sv
// Slew limiter top: AXI4-Lite register slave, clear and coupling gate
//
// Operation
// - Slew off: new code goes to the converter at once.
// - Slew on: output walks toward the target in discrete steps.
// - Four-bit rate code picks 64 kHz for zero down to 0.5 Hz.
// - Three-bit step code picks 1,2,4,16,32,64,128 or 256 LSBs.
// - All update rates come from dividing the 13 MHz oscillator.
// - Slew time equals change over step times rate times LSB.
// - With slew on, every change goes through stepping except a direct clear of an idle channel while another ramps.
// - Clear with slew on ramps an allowed channel to its clear code.
// - Clear during another channel's ramp may jump idle channels directly.
// - Update rate per code does not depend on output range.
// - Step counts converter code LSBs, current follows selected range.
// - Coupling input reaches the output only while output enabled.
// - Clear rising edge loads clear code on allowed channels only.
`timescale 1ns/1ps
module dsl_top
	import dsl_pkg::*;
#(
	parameter logic [31:0] OSC_HZ = 32'd13_000_000
) (
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	input  wire logic             s_axi_awvalid,
	output logic                  s_axi_awready,
	input  wire logic [7:0]       s_axi_awaddr,
	input  wire logic             s_axi_wvalid,
	output logic                  s_axi_wready,
	input  wire logic [31:0]      s_axi_wdata,
	input  wire logic [3:0]       s_axi_wstrb,
	output logic                  s_axi_bvalid,
	input  wire logic             s_axi_bready,
	output logic      [1:0]       s_axi_bresp,
	input  wire logic             s_axi_arvalid,
	output logic                  s_axi_arready,
	input  wire logic [7:0]       s_axi_araddr,
	output logic                  s_axi_rvalid,
	input  wire logic             s_axi_rready,
	output logic      [31:0]      s_axi_rdata,
	output logic      [1:0]       s_axi_rresp,
	input  wire logic             clearIn,
	input  wire logic [3:0]       modemCouplingInput,
	output logic      [3:0]       coupledOut,
	output logic      [3:0][15:0] dacCode
);

	typedef struct packed {
		logic             awready;
		logic             wready;
		logic             bvalid;
		logic [1:0]       bresp;
		logic             arready;
		logic             rvalid;
		logic [1:0]       rresp;
		logic [31:0]      rdata;
		logic             awHave;
		logic [7:0]       awAddr;
		logic             wHave;
		logic [31:0]      wData;
		logic [3:0]       wStrb;
		logic [3:0][15:0] target;
		logic [3:0][15:0] clrCode;
		logic [3:0][9:0]  ctrl;
		logic [3:0]       loadPulse;
		logic [3:0]       clrPulse;
		logic [3:0]       clrDirect;
		logic             clearPrev;
		logic [3:0]       coupled;
		logic [31:0]      oscAcc;
		logic             oscTick;
	} dsl_top_s;

	dsl_top_s    st;
	dsl_top_s    next_st;
	logic [3:0]  chBusy;

	////////////////////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic [31:0] apply_strb(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = data[b*8 +: 8];
			end
		end
		apply_strb = res;
	endfunction

	function automatic logic mapped(input logic [7:0] addr);
		mapped = (addr < MAP_LIMIT) && (addr[1:0] == 2'h0);
	endfunction

	function automatic logic [1:0] ch_of(input logic [7:0] addr);
		ch_of = addr[ADDR_CH_LSB +: 2];
	endfunction

	function automatic logic [1:0] reg_of(input logic [7:0] addr);
		reg_of = addr[ADDR_REG_LSB +: 2];
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		logic [32:0] accSum;
		logic [31:0] wval;
		logic [1:0]  ch;
		logic        clearRise;
		accSum    = 33'h0_0000_0000;
		wval      = 32'h0000_0000;
		ch        = 2'h0;
		clearRise = 1'b0;
		next_st           = st;
		next_st.loadPulse = 4'h0;
		next_st.clrPulse  = 4'h0;
		next_st.clrDirect = 4'h0;

		// Oscillator tick at the internal rate, fractional accumulator
		accSum = {1'b0, st.oscAcc} + {1'b0, OSC_HZ};
		if (accSum >= {1'b0, CLK_HZ}) begin
			next_st.oscAcc  = 32'(accSum - {1'b0, CLK_HZ});
			next_st.oscTick = 1'b1;
		end else begin
			next_st.oscAcc  = accSum[31:0];
			next_st.oscTick = 1'b0;
		end

		// Write channels, either order
		if (s_axi_awvalid && st.awready) begin
			next_st.awHave = 1'b1;
			next_st.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && st.wready) begin
			next_st.wHave = 1'b1;
			next_st.wData = s_axi_wdata;
			next_st.wStrb = s_axi_wstrb;
		end
		if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end
		if (next_st.awHave && next_st.wHave && !next_st.bvalid) begin
			ch = ch_of(next_st.awAddr);
			next_st.bresp = RESP_OKAY;
			if (!mapped(next_st.awAddr)) begin
				next_st.bresp = RESP_SLVERR;
			end else begin
				case (reg_of(next_st.awAddr))
					REG_TARGET: begin
						wval = apply_strb({16'h0000, st.target[ch]}, next_st.wData,
							next_st.wStrb);
						next_st.target[ch]    = wval[15:0];
						next_st.loadPulse[ch] = 1'b1;
					end
					REG_CLEARVAL: begin
						wval = apply_strb({16'h0000, st.clrCode[ch]}, next_st.wData,
							next_st.wStrb);
						next_st.clrCode[ch] = wval[15:0];
					end
					REG_CONTROL: begin
						wval = apply_strb({22'h00_0000, st.ctrl[ch]}, next_st.wData,
							next_st.wStrb);
						next_st.ctrl[ch] = wval[CTRL_WIDTH-1:0];
					end
					default: begin
						next_st.bresp = RESP_SLVERR;
					end
				endcase
			end
			next_st.awHave = 1'b0;
			next_st.wHave  = 1'b0;
			next_st.bvalid = 1'b1;
		end
		next_st.awready = !next_st.awHave && !next_st.bvalid;
		next_st.wready  = !next_st.wHave && !next_st.bvalid;

		// Read channel
		if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end
		if (s_axi_arvalid && st.arready) begin
			ch = ch_of(s_axi_araddr);
			next_st.rvalid = 1'b1;
			next_st.rresp  = RESP_OKAY;
			next_st.rdata  = 32'h0000_0000;
			if (!mapped(s_axi_araddr)) begin
				next_st.rresp = RESP_SLVERR;
			end else begin
				case (reg_of(s_axi_araddr))
					REG_TARGET:   next_st.rdata = {16'h0000, st.target[ch]};
					REG_CLEARVAL: next_st.rdata = {16'h0000, st.clrCode[ch]};
					REG_CONTROL:  next_st.rdata = {22'h00_0000, st.ctrl[ch]};
					default: begin
						next_st.rdata                = {16'h0000, dacCode[ch]};
						next_st.rdata[STAT_BUSY_BIT] = chBusy[ch];
					end
				endcase
			end
		end
		next_st.arready = !next_st.rvalid;

		// Clear edge and coupling gate
		clearRise         = clearIn && !st.clearPrev;
		next_st.clearPrev = clearIn;
		for (int i = 0; i < CHANNELS; i++) begin
			next_st.clrPulse[i]  = clearRise && st.ctrl[i][CTRL_CLRALW_BIT];
			next_st.clrDirect[i] = clearRise && (|chBusy) && !chBusy[i];
			next_st.coupled[i]   = modemCouplingInput[i] && st.ctrl[i][CTRL_OUTEN_BIT];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st         <= '0;
			st.ctrl    <= {CHANNELS{RST_CTRL}};
			st.target  <= {CHANNELS{RST_CODE}};
			st.clrCode <= {CHANNELS{RST_CODE}};
		end else begin
			st <= next_st;
		end
	end

	assign s_axi_awready = st.awready;
	assign s_axi_wready  = st.wready;
	assign s_axi_bvalid  = st.bvalid;
	assign s_axi_bresp   = st.bresp;
	assign s_axi_arready = st.arready;
	assign s_axi_rvalid  = st.rvalid;
	assign s_axi_rdata   = st.rdata;
	assign s_axi_rresp   = st.rresp;
	assign coupledOut    = st.coupled;

	////////////////////////////////////////////////////////////////////////////////
	// Channels
	for (genvar g = 0; g < CHANNELS; g++) begin : gCh
		dsl_channel #(
			.OSC_HZ(OSC_HZ)
		) uChannel (
			.ref_clk    (ref_clk),
			.rst_n      (rst_n),
			.oscTick    (st.oscTick),
			.slewEnable (st.ctrl[g][CTRL_SLEW_BIT]),
			.rateSel    (st.ctrl[g][CTRL_RATE_LSB +: 4]),
			.stepSel    (st.ctrl[g][CTRL_STEP_LSB +: 3]),
			.target     (st.target[g]),
			.loadStrobe (st.loadPulse[g]),
			.clearCode  (st.clrCode[g]),
			.clearStrobe(st.clrPulse[g]),
			.clearDirect(st.clrDirect[g]),
			.code       (dacCode[g]),
			.busy       (chBusy[g])
		);

		////////////////////////////////////////////////////////////////////////////
		// Checks
		property p_clr_gate;
			@(posedge ref_clk) disable iff (!rst_n)
			(clearIn && !st.clearPrev)
			|=> (st.clrPulse[g] == $past(st.ctrl[g][CTRL_CLRALW_BIT]));
		endproperty
		a_clr_gate: assert property (p_clr_gate) else $error("clear gating wrong");

		property p_clr_edge;
			@(posedge ref_clk) disable iff (!rst_n)
			st.clrPulse[g] |-> $past(clearIn) && !$past(st.clearPrev);
		endproperty
		a_clr_edge: assert property (p_clr_edge) else $error("clear not edge");

		property p_couple;
			@(posedge ref_clk) disable iff (!rst_n)
			##1 (coupledOut[g] == ($past(modemCouplingInput[g])
				&& $past(st.ctrl[g][CTRL_OUTEN_BIT])));
		endproperty
		a_couple: assert property (p_couple) else $error("coupling gate wrong");

		property p_clr_direct;
			@(posedge ref_clk) disable iff (!rst_n)
			(st.clrPulse[g] && st.clrDirect[g]) |=> (dacCode[g] == $past(st.clrCode[g]));
		endproperty
		a_clr_direct: assert property (p_clr_direct) else $error("direct clear missed");

		property p_clr_ramp;
			@(posedge ref_clk) disable iff (!rst_n)
			(st.clrPulse[g] && !st.clrDirect[g] && st.ctrl[g][CTRL_SLEW_BIT] && !chBusy[g]
				&& (dsl_dist(st.clrCode[g], dacCode[g]) > 16'h0100))
			|=> (dacCode[g] == $past(dacCode[g])) && chBusy[g];
		endproperty
		a_clr_ramp: assert property (p_clr_ramp) else $error("clear did not ramp");
	end

endmodule

// file: dv/test_dac_digital_slew_limiter.sv
// Testbench of the slew limiter: register access, stepping, clear and coupling
`timescale 1ns/1ps
module test_dac_digital_slew_limiter import dsl_pkg::*;
;
	typedef struct {
		logic [2:0]  stepSel;
		logic [3:0]  rateSel;
		logic [15:0] step;
		int          period;
	} dsl_row_s;

	logic             ref_clk;
	logic             rst_n;
	logic             s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic             s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic             s_axi_rvalid, s_axi_rready;
	logic [7:0]       s_axi_awaddr, s_axi_araddr;
	logic [31:0]      s_axi_wdata, s_axi_rdata;
	logic [3:0]       s_axi_wstrb;
	logic [1:0]       s_axi_bresp, s_axi_rresp;
	logic             clearIn;
	logic [3:0]       modemCouplingInput;
	logic [3:0]       coupledOut;
	logic [3:0][15:0] dacCode;
	int               nErrors;
	int               totalChecks;
	dsl_row_s         rows [8];

	////////////////////////////////////////////////////////////////////////////////
	// Oscillator set to the system rate so one step period is 781 clocks at 64 kHz
	dsl_top #(.OSC_HZ(32'd50_000_000)) DUT (
		.ref_clk(ref_clk), .rst_n(rst_n),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .clearIn(clearIn),
		.modemCouplingInput(modemCouplingInput), .coupledOut(coupledOut),
		.dacCode(dacCode)
	);

	always #10 ref_clk = ~ref_clk;

	////////////////////////////////////////////////////////////////////////////////
	// Compare, bus and closing tasks
	task automatic chkWord(input string what, input logic [31:0] exp, input logic [31:0] got);
		totalChecks++;
		if (got !== exp) begin
			nErrors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chkResp(input string what, input logic [1:0] exp, input logic [1:0] got);
		totalChecks++;
		if (got !== exp) begin
			nErrors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		bit awDone;
		bit wDone;
		awDone = 0;
		wDone = 0;
		s_axi_awvalid <= 1'b1;
		s_axi_awaddr  <= a;
		s_axi_wvalid  <= 1'b1;
		s_axi_wdata   <= d;
		s_axi_bready  <= 1'b1;
		while (!(awDone && wDone)) begin
			@(posedge ref_clk);
			if (s_axi_awvalid && s_axi_awready) begin
				awDone = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wDone = 1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_arvalid <= 1'b1;
		s_axi_araddr  <= a;
		s_axi_rready  <= 1'b1;
		do @(posedge ref_clk); while (!(s_axi_arvalid && s_axi_arready));
		s_axi_arvalid <= 1'b0;
		do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic wr(input int ch, input int rg, input logic [31:0] d);
		logic [1:0] r;
		axiWrite(8'(ch * 16 + rg * 4), d, r);
		chkResp("writeResp", RESP_OKAY, r);
	endtask

	task automatic rdChk(input string what, input int ch, input int rg, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		axiRead(8'(ch * 16 + rg * 4), d, r);
		chkResp("readResp", RESP_OKAY, r);
		chkWord(what, e, d);
	endtask

	// Clocks until a channel code moves, bounded
	task automatic waitChange(input int ch, output int cyc);
		logic [15:0] old;
		old = dacCode[ch];
		cyc = 0;
		do begin
			@(posedge ref_clk);
			cyc++;
		end while (dacCode[ch] === old && cyc < 20000);
	endtask

	task automatic reportAndStop;
		$display("Checks %0d, errors %0d", totalChecks, nErrors);
		if (nErrors == 0 && totalChecks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Watchdog: the run needs about 43000 clocks
	initial begin
		repeat (90000) @(posedge ref_clk);
		nErrors++;
		reportAndStop();
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		int          c;
		logic [31:0] d;
		logic [1:0]  r;
		ref_clk = 1'b0;
		rst_n = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0000_0000;
		s_axi_wstrb = 4'hF;
		clearIn = 1'b0;
		modemCouplingInput = 4'h0;
		nErrors = 0;
		totalChecks = 0;
		rows = '{'{3'd0, 4'd0, 16'h0001, 781}, '{3'd1, 4'd1, 16'h0002, 1562},
			'{3'd2, 4'd2, 16'h0004, 3125}, '{3'd3, 4'd3, 16'h0010, 6250},
			'{3'd4, 4'd0, 16'h0020, 781}, '{3'd5, 4'd0, 16'h0040, 781},
			'{3'd6, 4'd0, 16'h0080, 781}, '{3'd7, 4'd0, 16'h0100, 781}};
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge ref_clk);
		for (int i = 0; i < 4; i++) begin
			chkWord("resetCode", 32'h0000_0000, {16'h0000, dacCode[i]});
		end
		chkWord("resetCoupled", 32'h0000_0000, {28'h0, coupledOut});
		rdChk("resetControl", 1, 2, 32'h0000_0000);
		rdChk("resetStatus", 2, 3, 32'h0000_0000);

		// Row loop: each step code, rate codes 0 to 3, first two steps on channel 0
		foreach (rows[i]) begin
			wr(0, 2, 32'h0000_0000);
			wr(0, 0, 32'h0000_0000);
			wr(0, 2, {24'h0, rows[i].stepSel, rows[i].rateSel, 1'b1});
			wr(0, 0, 32'h0000_1000);
			chkWord("noJump", 32'h0000_0000, {16'h0, dacCode[0]});
			waitChange(0, c);
			chkWord("firstStep", {16'h0, rows[i].step}, {16'h0, dacCode[0]});
			waitChange(0, c);
			chkWord("secondStep", {15'h0, rows[i].step, 1'b0}, {16'h0, dacCode[0]});
			chkWord("stepPeriod", rows[i].period, c);
		end

		// Direct update with slew off, unmapped and read-only places
		wr(0, 2, 32'h0000_0000);
		wr(3, 0, 32'h0000_BEEF);
		@(posedge ref_clk);
		chkWord("directCode", 32'h0000_BEEF, {16'h0, dacCode[3]});
		axiRead(8'h44, d, r);
		chkResp("unmappedResp", RESP_SLVERR, r);
		chkWord("unmappedData", 32'h0000_0000, d);
		axiWrite(8'h0C, 32'h0000_1234, r);
		chkResp("statusWrite", RESP_SLVERR, r);
		axiWrite(8'h02, 32'h0000_1234, r);
		chkResp("unalignedWrite", RESP_SLVERR, r);

		// Last step shorter than step size lands on target
		wr(1, 2, 32'h0000_0045);
		wr(1, 0, 32'h0000_0005);
		waitChange(1, c);
		rdChk("midStatus", 1, 3, 32'h0001_0004);
		waitChange(1, c);
		chkWord("landCode", 32'h0000_0005, {16'h0, dacCode[1]});
		rdChk("landStatus", 1, 3, 32'h0000_0005);
		repeat (800) @(posedge ref_clk);
		chkWord("stayCode", 32'h0000_0005, {16'h0, dacCode[1]});

		// Clear while channel 3 ramps: allowed idle ones jump, busy one keeps stepping
		wr(3, 2, 32'h0000_0000);
		wr(3, 0, 32'h0000_0000);
		wr(0, 1, 32'h0000_0123);
		wr(0, 2, 32'h0000_0300);
		wr(1, 2, 32'h0000_0000);
		wr(1, 0, 32'h0000_0777);
		wr(1, 1, 32'h0000_0456);
		wr(2, 1, 32'h0000_0040);
		wr(2, 2, 32'h0000_0361);
		wr(3, 1, 32'h0000_0050);
		wr(3, 2, 32'h0000_0107);
		wr(3, 0, 32'h0000_0100);
		clearIn <= 1'b1;
		repeat (4) @(posedge ref_clk);
		chkWord("clearAllowed", 32'h0000_0123, {16'h0, dacCode[0]});
		chkWord("clearBlocked", 32'h0000_0777, {16'h0, dacCode[1]});
		chkWord("clearDirect", 32'h0000_0040, {16'h0, dacCode[2]});
		chkWord("clearRampHold", 32'h0000_0000, {16'h0, dacCode[3]});
		waitChange(3, c);
		chkWord("clearRampStep", 32'h0000_0001, {16'h0, dacCode[3]});
		wr(0, 0, 32'h0000_0999);
		@(posedge ref_clk);
		chkWord("levelNoClear", 32'h0000_0999, {16'h0, dacCode[0]});
		clearIn <= 1'b0;

		// Coupling gated by output enable: channels 0 and 2 enabled
		modemCouplingInput <= 4'hF;
		repeat (3) @(posedge ref_clk);
		chkWord("coupledAll", 32'h0000_0005, {28'h0, coupledOut});
		modemCouplingInput <= 4'hA;
		repeat (3) @(posedge ref_clk);
		chkWord("coupledSome", 32'h0000_0000, {28'h0, coupledOut});
		reportAndStop();
	end

endmodule
